// File: pkg/aclc_defs.vh
`ifndef ACLC_DEFS_VH
`define ACLC_DEFS_VH
// Slot geometry of one frame
`define ACLC_SLOT_W        20
`define ACLC_TAG_W         16
`define ACLC_SLOT_LAST_BIT 5'd19
`define ACLC_TAG_LAST_BIT  5'd15
`define ACLC_LAST_SLOT     4'd12
// Slot numbers with payload
`define ACLC_SLOT_TAG      4'd0
`define ACLC_SLOT_CMD_ADDR 4'd1
`define ACLC_SLOT_CMD_DATA 4'd2
`define ACLC_SLOT_PCM_L    4'd3
`define ACLC_SLOT_PCM_R    4'd4
// Tag bit positions
`define ACLC_TAG_FRAME_BIT 15
`define ACLC_TAG_ADDR_BIT  14
`define ACLC_TAG_DATA_BIT  13
`define ACLC_TAG_PCML_BIT  12
`define ACLC_TAG_PCMR_BIT  11
`define ACLC_TAG_READY_BIT 15
// Transmit FIFO shape
`define ACLC_FIFO_DEPTH    8
`define ACLC_FIFO_AW       3
// Reset values
`define ACLC_RST_SLOT      4'd12
`define ACLC_RST_BIT       5'd19
`define ACLC_RST_WORD      20'h0_0000
// Fetch sequencer states
`define ACLC_FETCH_IDLE    2'd0
`define ACLC_FETCH_LEFT    2'd1
`define ACLC_FETCH_RIGHT   2'd2
`endif

// File: rtl/aclc_fifo.v
`timescale 1ns/1ns
`default_nettype none
module aclc_fifo #(
  parameter WIDTH = 20,
  parameter DEPTH = 8,
  parameter AW    = 3
) (
  input  wire             core_clk,
  input  wire             rst,
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // Storage words
  reg [AW-1:0]    wrPtr_reg;       // Write pointer
  reg [AW-1:0]    rdPtr_reg;       // Read pointer
  reg [AW:0]      count_reg;       // Words held
  reg             notFull_reg;     // Registered not-full flag
  reg             notEmpty_reg;    // Registered not-empty flag
  reg [AW:0]      count_next;
  wire            push;
  wire            pop;

  assign push     = inValid & notFull_reg;
  assign pop      = outReady & notEmpty_reg;
  assign inReady  = notFull_reg;
  assign outValid = notEmpty_reg;
  assign outData  = mem[rdPtr_reg];

  // Next occupancy
  always @* begin
    count_next = count_reg;
    if (push & ~pop) begin
      count_next = count_reg + {{AW{1'b0}}, 1'b1};
    end else if (pop & ~push) begin
      count_next = count_reg - {{AW{1'b0}}, 1'b1};
    end
  end

  // Pointers and flags
  always @(posedge core_clk) begin
    if (rst) begin
      wrPtr_reg    <= {AW{1'b0}};
      rdPtr_reg    <= {AW{1'b0}};
      count_reg    <= {(AW+1){1'b0}};
      notFull_reg  <= 1'b1;
      notEmpty_reg <= 1'b0;
    end else begin
      if (push) begin
        wrPtr_reg <= wrPtr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rdPtr_reg <= rdPtr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      count_reg    <= count_next;
      notFull_reg  <= (count_next != DEPTH[AW:0]);
      notEmpty_reg <= (count_next != {(AW+1){1'b0}});
    end
  end

  // Word storage
  always @(posedge core_clk) begin
    if (push) begin
      mem[wrPtr_reg] <= inData;
    end
  end
endmodule
`default_nettype wire

// File: rtl/aclc_link_port.v
// What this block does
// (R01) Sync high marks each frame's tag slot
// (R02) All link timing follows codec bit clock
// (R03) Send outgoing slots serially on data out
// (R04) Capture codec's serial slots from data in
// (R05) Codec reset output with own control
// (R06) No payload until codec reports ready; command slots go out whether or not the codec is ready
// (R07) 256-bit frame, tag plus twelve slots
`timescale 1ns/1ns
`default_nettype none
`include "aclc_defs.vh"
module aclc_link_port (
  input  wire        core_clk,
  input  wire        rst,
  input  wire        bitClk,
  input  wire        sdataIn,
  output reg         sync,
  output reg         sdataOut,
  output reg         codecMasterResetN,
  input  wire        codecResetAssert,
  input  wire        txValid,
  output wire        txReady,
  input  wire [19:0] txData,
  input  wire        cmdStart,
  input  wire [19:0] cmdAddr,
  input  wire [19:0] cmdData,
  output reg         cmdBusy,
  output reg         cmdDone,
  output reg         codecReady,
  output reg         rxValid,
  output reg  [3:0]  rxSlot,
  output reg  [19:0] rxData
);
  reg        bclkMeta_reg;   // Bit clock, first sync stage
  reg        bclkSync_reg;   // Bit clock, second sync stage
  reg        bclkLast_reg;   // Previous synced bit clock
  reg        sdinMeta_reg;   // Data in, first sync stage
  reg        sdinSync_reg;   // Data in, second sync stage
  reg [3:0]  slot_reg;       // Current slot
  reg [4:0]  bit_reg;        // Bit within slot
  reg [19:0] txShift_reg;    // Outgoing shift register
  reg [19:0] rxShift_reg;    // Incoming shift register
  reg        frameSeen_reg;  // First frame has begun
  reg [1:0]  fetch_reg;      // Payload fetch state
  reg [19:0] left_reg;       // Left PCM word for next frame
  reg [19:0] right_reg;      // Right PCM word for next frame
  reg        leftValid_reg;  // Left word present
  reg        rightValid_reg; // Right word present
  reg [19:0] cmdAddr_reg;    // Latched command address
  reg [19:0] cmdData_reg;    // Latched command data
  reg        cmdPend_reg;    // Command waiting to go out
  reg        cmdSent_reg;    // Command tagged in current frame
  reg [3:0]  slot_next;
  reg [4:0]  bit_next;
  reg [19:0] word_next;
  wire       bclkRise;
  wire       bclkFall;
  wire       fifoValid;
  wire       fifoPop;
  wire [19:0] fifoData;
  wire [19:0] rxShifted;
  // Payload fetch sequencer states
  localparam [1:0] FETCH_IDLE  = `ACLC_FETCH_IDLE;  // Waiting for slot 12
  localparam [1:0] FETCH_LEFT  = `ACLC_FETCH_LEFT;  // Taking the left word
  localparam [1:0] FETCH_RIGHT = `ACLC_FETCH_RIGHT; // Taking the right word

  assign bclkRise  = bclkSync_reg & ~bclkLast_reg;
  assign bclkFall  = ~bclkSync_reg & bclkLast_reg;
  assign rxShifted = {rxShift_reg[18:0], sdinSync_reg};
  // Pop only while fetching and only once the codec is ready
  assign fifoPop   = fifoValid & codecReady & ((fetch_reg == FETCH_LEFT) |
                     (fetch_reg == FETCH_RIGHT)); // R06

  // Last bit index of a slot: tag slot is shorter
  function [4:0] lastBit;
    input [3:0] s;
    begin
      lastBit = (s == `ACLC_SLOT_TAG) ? `ACLC_TAG_LAST_BIT : `ACLC_SLOT_LAST_BIT; // R07
    end
  endfunction

  // Outgoing word for a slot, tag left-justified
  function [19:0] slotWord;
    input [3:0] s;
    reg   [15:0] tag;
    begin
      tag = 16'h0000;
      tag[`ACLC_TAG_FRAME_BIT] = cmdPend_reg | leftValid_reg | rightValid_reg;
      tag[`ACLC_TAG_ADDR_BIT]  = cmdPend_reg;
      tag[`ACLC_TAG_DATA_BIT]  = cmdPend_reg;
      tag[`ACLC_TAG_PCML_BIT]  = leftValid_reg;
      tag[`ACLC_TAG_PCMR_BIT]  = rightValid_reg;
      case (s)
        `ACLC_SLOT_TAG:      slotWord = {tag, 4'h0};
        `ACLC_SLOT_CMD_ADDR: slotWord = cmdPend_reg ? cmdAddr_reg : `ACLC_RST_WORD;
        `ACLC_SLOT_CMD_DATA: slotWord = cmdPend_reg ? cmdData_reg : `ACLC_RST_WORD;
        `ACLC_SLOT_PCM_L:    slotWord = leftValid_reg ? left_reg : `ACLC_RST_WORD; // R06
        `ACLC_SLOT_PCM_R:    slotWord = rightValid_reg ? right_reg : `ACLC_RST_WORD; // R06
        default:             slotWord = `ACLC_RST_WORD;
      endcase
    end
  endfunction

  // Transmit FIFO in the payload path
  aclc_fifo #(
    .WIDTH (`ACLC_SLOT_W),
    .DEPTH (`ACLC_FIFO_DEPTH),
    .AW    (`ACLC_FIFO_AW)
  ) uFifo (
    .core_clk (core_clk),
    .rst      (rst),
    .inValid  (txValid),
    .inReady  (txReady),
    .inData   (txData),
    .outValid (fifoValid),
    .outReady (fifoPop),
    .outData  (fifoData)
  );

  // Two-stage synchronisers for the link pins
  always @(posedge core_clk) begin
    if (rst) begin
      bclkMeta_reg <= 1'b0;
      bclkSync_reg <= 1'b0;
      bclkLast_reg <= 1'b0;
      sdinMeta_reg <= 1'b0;
      sdinSync_reg <= 1'b0;
    end else begin
      bclkMeta_reg <= bitClk; // R02
      bclkSync_reg <= bclkMeta_reg;
      bclkLast_reg <= bclkSync_reg;
      sdinMeta_reg <= sdataIn;
      sdinSync_reg <= sdinMeta_reg;
    end
  end

  // Next frame position on a rising bit clock edge
  always @* begin
    slot_next = slot_reg;
    bit_next  = bit_reg + 5'd1;
    word_next = {txShift_reg[18:0], 1'b0};
    if (bit_reg == lastBit(slot_reg)) begin
      // Wrap after slot 12 back to the tag slot
      slot_next = (slot_reg == `ACLC_LAST_SLOT) ? `ACLC_SLOT_TAG : slot_reg + 4'd1; // R07
      bit_next  = 5'd0;
      word_next = slotWord(slot_next);
    end
  end

  // Frame counter and serial output, changing on rising bit clock
  always @(posedge core_clk) begin
    if (rst | codecResetAssert) begin
      slot_reg    <= `ACLC_RST_SLOT;
      bit_reg     <= `ACLC_RST_BIT;
      txShift_reg <= `ACLC_RST_WORD;
      sync        <= 1'b0;
      sdataOut    <= 1'b0;
      cmdSent_reg <= 1'b0;
    end else if (bclkRise) begin // R02
      slot_reg    <= slot_next;
      bit_reg     <= bit_next;
      txShift_reg <= word_next;
      sdataOut    <= word_next[19]; // R03
      sync        <= (slot_next == `ACLC_SLOT_TAG); // R01
      if ((slot_next == `ACLC_SLOT_TAG) && (bit_next == 5'd0)) begin
        cmdSent_reg <= cmdPend_reg;
      end
    end
  end

  // Incoming capture on falling bit clock
  always @(posedge core_clk) begin
    if (rst | codecResetAssert) begin
      rxShift_reg   <= `ACLC_RST_WORD;
      frameSeen_reg <= 1'b0;
      rxValid       <= 1'b0;
      rxSlot        <= 4'h0;
      rxData        <= `ACLC_RST_WORD;
      codecReady    <= 1'b0;
    end else begin
      rxValid <= 1'b0;
      if (bclkRise && (slot_next == `ACLC_SLOT_TAG)) begin
        frameSeen_reg <= 1'b1;
      end
      if (bclkFall && frameSeen_reg) begin // R04
        rxShift_reg <= rxShifted;
        if (bit_reg == lastBit(slot_reg)) begin
          // Whole slot received
          rxValid <= 1'b1;
          rxSlot  <= slot_reg;
          if (slot_reg == `ACLC_SLOT_TAG) begin
            rxData     <= {4'h0, rxShifted[15:0]};
            codecReady <= rxShifted[`ACLC_TAG_READY_BIT]; // R06
          end else begin
            rxData <= rxShifted;
          end
        end
      end
    end
  end

  // Payload fetch before each tag slot
  always @(posedge core_clk) begin
    if (rst | codecResetAssert) begin
      fetch_reg      <= FETCH_IDLE;
      left_reg       <= `ACLC_RST_WORD;
      right_reg      <= `ACLC_RST_WORD;
      leftValid_reg  <= 1'b0;
      rightValid_reg <= 1'b0;
    end else begin
      case (fetch_reg)
        FETCH_IDLE: begin
          // Slot 12 start leaves many core cycles before the next tag
          if (bclkRise && (slot_next == `ACLC_LAST_SLOT) && (bit_next == 5'd0)) begin
            fetch_reg <= FETCH_LEFT;
          end
        end
        FETCH_LEFT: begin
          left_reg      <= fifoData;
          leftValid_reg <= fifoPop; // R06
          fetch_reg     <= FETCH_RIGHT;
        end
        FETCH_RIGHT: begin
          right_reg      <= fifoData;
          rightValid_reg <= fifoPop; // R06
          fetch_reg      <= FETCH_IDLE;
        end
        default: begin
          fetch_reg <= FETCH_IDLE;
        end
      endcase
    end
  end

  // Command slots: accepted while idle, retired after one frame
  always @(posedge core_clk) begin
    if (rst | codecResetAssert) begin
      cmdPend_reg <= 1'b0;
      cmdAddr_reg <= `ACLC_RST_WORD;
      cmdData_reg <= `ACLC_RST_WORD;
      cmdBusy     <= 1'b0;
      cmdDone     <= 1'b0;
    end else begin
      cmdDone <= 1'b0;
      if ((fetch_reg == FETCH_LEFT) && cmdSent_reg && cmdPend_reg) begin
        // Frame carrying the command has gone out
        cmdPend_reg <= 1'b0;
        cmdBusy     <= 1'b0;
        cmdDone     <= 1'b1;
      end else if (cmdStart && !cmdBusy) begin
        cmdPend_reg <= 1'b1;
        cmdBusy     <= 1'b1;
        cmdAddr_reg <= cmdAddr;
        cmdData_reg <= cmdData;
      end
    end
  end

  // Codec master reset, driven low by core reset and otherwise by its own control input
  always @(posedge core_clk) begin
    if (rst) begin
      codecMasterResetN <= 1'b0;
    end else begin
      codecMasterResetN <= ~codecResetAssert; // R05
    end
  end
endmodule
`default_nettype wire

// File: verification/aclc_link_port_properties.sv
`timescale 1ns/1ns
`default_nettype none
module aclc_link_port_properties (
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       sync,
  input wire logic       sdataOut,
  input wire logic       codecMasterResetN,
  input wire logic       codecResetAssert,
  input wire logic       txReady,
  input wire logic       cmdStart,
  input wire logic       cmdBusy,
  input wire logic       cmdDone,
  input wire logic       codecReady,
  input wire logic       rxValid,
  input wire logic [3:0] rxSlot
);
  int   syncLen;  // Cycles sync has stood high, a bit clock is 8
  int   frameLen; // Cycles since the last sync rise
  logic hold;     // Link was reset or frozen last cycle
  logic frameOk;  // A sync rise has been seen since the freeze
  // Helper counters for the frame geometry
  always @(posedge core_clk) begin
    hold     <= rst | codecResetAssert;
    syncLen  <= sync ? syncLen + 1 : 0;
    frameLen <= $rose(sync) ? 1 : frameLen + 1;
    frameOk  <= hold ? 1'b0 : ($rose(sync) | frameOk);
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst || hold);
  sequence s_accept; cmdStart && !cmdBusy; endsequence
  sequence s_start; $rose(sync) && frameOk; endsequence
  AST_RST_STATE: assert property (disable iff (1'b0) rst |=> !codecMasterResetN && txReady)
    else $error("reset state wrong");
  AST_NRST_FOLLOW: assert property (disable iff (rst) 1 |=> codecMasterResetN == !$past(codecResetAssert))
    else $error("codec reset output wrong");
  AST_SYNC_WIDTH: assert property ($fell(sync) |-> syncLen >= 127 && syncLen <= 129)
    else $error("sync width wrong");
  AST_FRAME_LEN: assert property (s_start |-> frameLen >= 2047 && frameLen <= 2049)
    else $error("frame length wrong");
  AST_FROZEN: assert property (disable iff (rst) codecResetAssert [*2] |-> !sync && !sdataOut)
    else $error("link not frozen");
  AST_TX_HELD: assert property (!codecReady && !$past(codecReady) && !txReady |=> !txReady)
    else $error("fifo drained while not ready");
  AST_CMD_TAKEN: assert property (s_accept |=> cmdBusy)
    else $error("command not taken");
  AST_CMD_DONE: assert property (cmdDone |-> $past(cmdBusy) && !cmdBusy ##1 !cmdDone)
    else $error("done pulse wrong");
  AST_RX_PULSE: assert property (rxValid |-> rxSlot <= 4'd12 ##1 !rxValid)
    else $error("receive pulse wrong");
endmodule
bind aclc_link_port aclc_link_port_properties u_props (.core_clk, .rst, .sync, .sdataOut,
  .codecMasterResetN, .codecResetAssert, .txReady, .cmdStart, .cmdBusy, .cmdDone, .codecReady,
  .rxValid, .rxSlot);
`default_nettype wire

// File: verification/aclc_codec_model.sv
`timescale 1ns/1ns
`default_nettype none
module aclc_codec_model (
  input  wire logic        sync,
  input  wire logic        sdataOut,
  input  wire logic        codecMasterResetN,
  input  wire logic        ready,
  output var  logic        bitClk,
  output var  logic        sdataIn,
  output var  logic [15:0] tagOut,
  output var  logic [19:0] slotOut [1:4],
  output var  int          frames
);
  logic [19:0] sh       = 20'h0_0000; // Outgoing bits, newest last
  logic [19:0] w;                     // Word of the slot being returned
  logic [7:0]  pos      = 8'h00;      // Bit position in the frame
  logic        syncLast = 1'b0;       // Sync at the previous rising edge
  // Free-running bit clock, stopped while the codec is held in reset
  initial begin
    bitClk = 1'b0;
    #7;
    forever #80 bitClk = codecMasterResetN ? !bitClk : 1'b0;
  end
  // Capture the previous bit and return the next at each rising edge
  always @(posedge bitClk) begin
    sh       = {sh[18:0], sdataOut};
    pos      = (sync && !syncLast) ? 8'd1 : pos + 8'd1;
    syncLast = sync;
    if (pos == 8'd16) tagOut = sh[15:0];
    if (pos >= 8'd36 && pos <= 8'd96 && (pos - 8'd16) % 20 == 0) begin
      slotOut[(pos - 8'd16) / 20] = sh;
      if (pos == 8'd96) frames++;
    end
    w       = {4'((pos - 8'd16) / 20 + 1), 16'hA5C3};
    sdataIn <= (pos < 8'd16) ? (pos == 8'd0) & ready : w[19 - (pos - 8'd16) % 20];
  end
endmodule
`default_nettype wire

// File: verification/test_aclc_link_port.sv
`timescale 1ns/1ns
`default_nettype none
module test_aclc_link_port;
  logic        core_clk = 1'b0, rst, bitClk, sdataIn, sync, sdataOut, codecMasterResetN;
  logic        codecResetAssert, txValid, txReady, cmdStart, cmdBusy, cmdDone;
  logic        codecReady, rxValid, ready;
  logic [19:0] txData, cmdAddr, cmdData, rxData, slotOut [1:4], rxSeen [0:12], got [$];
  logic [15:0] tagOut;
  logic [3:0]  rxSlot;
  int          frames, n_errors, compares;
  aclc_link_port DUT (.core_clk, .rst, .bitClk, .sdataIn, .sync, .sdataOut, .codecMasterResetN,
    .codecResetAssert, .txValid, .txReady, .txData, .cmdStart, .cmdAddr, .cmdData, .cmdBusy,
    .cmdDone, .codecReady, .rxValid, .rxSlot, .rxData);
  aclc_codec_model u_codec (.sync, .sdataOut, .codecMasterResetN, .ready, .bitClk, .sdataIn,
    .tagOut, .slotOut, .frames);
  // Core clock, 20 ns
  always #10 core_clk = !core_clk;
  // Last word seen per received slot
  always @(posedge core_clk) if (rxValid) rxSeen[rxSlot] <= rxData;
  // PCM words the codec got, left before right
  always @(frames) begin
    if (tagOut[12]) got.push_back(slotOut[3]);
    if (tagOut[11]) got.push_back(slotOut[4]);
  end
  task check(input string name, input logic [19:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s exp %h seen %h", name, exp, seen);
    end
  endtask
  task chk1(input string name, input logic seen, exp);
    check(name, {19'h0, seen}, {19'h0, exp});
  endtask
  task finish_test;
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Bounded wait for a number of frames seen by the codec
  task waitFrames(input int n);
    int f;
    f = frames;
    for (int i = 0; i < n * 2100 && frames < f + n; i++) @(negedge core_clk);
  endtask
  // Codec reset has its own control and freezes the link
  task test_reset;
    chk1("nrst", codecMasterResetN, 1'b1);
    codecResetAssert = 1;
    repeat (2) @(negedge core_clk);
    chk1("nrst on", codecMasterResetN, 1'b0);
    chk1("sync frozen", sync, 1'b0);
    codecResetAssert = 0;
    @(negedge core_clk);
    chk1("nrst off", codecMasterResetN, 1'b1);
  endtask
  // Fill the FIFO until it refuses while the codec is not ready
  task test_fill;
    int n;
    n = 0;
    for (int i = 0; i < 12; i++) begin
      txValid = 1;
      txData  = 20'h5_0000 + n[19:0];
      if (txReady) n++;
      @(negedge core_clk);
    end
    txValid = 0;
    check("fill", n[19:0], 20'h0_0008);
    waitFrames(2);
    check("tag", {4'h0, tagOut}, 20'h0_0000);
    check("pcm", slotOut[3], 20'h0_0000);
    chk1("not ready", codecReady, 1'b0);
  endtask
  // Ready codec: slots captured, FIFO drained in order
  task test_rx;
    ready = 1;
    waitFrames(3);
    chk1("ready", codecReady, 1'b1);
    check("slot0", rxSeen[0], 20'h0_8000);
    check("slot3", rxSeen[3], 20'h3_A5C3);
    check("slot12", rxSeen[12], 20'hC_A5C3);
    waitFrames(4);
    check("words", 20'(got.size()), 20'h0_0008);
    for (int k = 0; k < 8; k++) check("word", got[k], 20'h5_0000 + k[19:0]);
    chk1("drained", txReady, 1'b1);
  endtask
  // Two commands back to back
  task test_cmd;
    for (int k = 0; k < 2; k++) begin
      cmdAddr  = 20'h1_2340 + k[19:0];
      cmdData  = 20'hA_BC00 + k[19:0];
      cmdStart = 1;
      @(negedge core_clk);
      cmdStart = 0;
      chk1("busy", cmdBusy, 1'b1);
      for (int i = 0; i < 5000 && cmdDone !== 1'b1; i++) @(negedge core_clk);
      chk1("done", cmdDone, 1'b1);
      check("addr", slotOut[1], cmdAddr);
      check("data", slotOut[2], cmdData);
      chk1("cmd tag", tagOut[14], 1'b1);
      @(negedge core_clk);
    end
  endtask
  // Codec reset freezes a running link in its tag; core reset empties the FIFO
  task test_freeze;
    repeat (200) @(negedge core_clk);
    chk1("tag sync", sync, 1'b1);
    codecResetAssert = 1;
    txValid = 1;
    repeat (9) @(negedge core_clk);
    txValid = 0;
    chk1("frz nrst", codecMasterResetN, 1'b0);
    chk1("frz sync", sync, 1'b0);
    chk1("frz ready", codecReady, 1'b0);
    chk1("frz full", txReady, 1'b0);
    rst = 1;
    repeat (5) @(negedge core_clk);
    rst = 0;
    codecResetAssert = 0;
    @(negedge core_clk);
    chk1("rst empty", txReady, 1'b1);
    chk1("rst busy", cmdBusy, 1'b0);
    chk1("rst nrst", codecMasterResetN, 1'b1);
    waitFrames(3);
    chk1("ready again", codecReady, 1'b1);
    chk1("no pcm", tagOut[12], 1'b0);
  endtask
  // Main sequence
  initial begin
    {txValid, cmdStart, ready, codecResetAssert} = '0;
    {txData, cmdAddr, cmdData} = '0;
    n_errors = 0;
    compares = 0;
    rst = 1;
    repeat (5) @(negedge core_clk);
    rst = 0;
    @(negedge core_clk);
    test_reset;
    test_fill;
    test_rx;
    test_cmd;
    test_freeze;
    finish_test;
  end
  // Watchdog, about three times the expected run
  initial begin
    #1800000;
    n_errors++;
    finish_test;
  end
endmodule
`default_nettype wire
